//--- hw/scan_mean_regs.vh
`ifndef SCAN_MEAN_REGS_VH
`define SCAN_MEAN_REGS_VH

// ------------------------------------------------------------
// Channel widths
// ------------------------------------------------------------
`define SM_DIST_W 16
`define SM_RSSI_W 16
`define SM_ANG_W 16
`define SM_QUAL_W 8
`define SM_SCAN_W 16
`define SM_CNT_W 8
`define SM_SUM_W 24
`define SM_IDX_W 10

// ------------------------------------------------------------
// Scan geometry: native step is 1/12 degree, 70 degrees wide
// ------------------------------------------------------------
`define SM_NATIVE_PER_DEG 12
`define SM_RANGE_DEG 70
`define SM_MAX_POINTS 841
`define SM_LAST_INDEX 10'h348

// ------------------------------------------------------------
// Buffer word layout (lowest bit of each field) and size
// ------------------------------------------------------------
`define SM_F_DIST 0
`define SM_F_RSSI 16
`define SM_F_ANG 32
`define SM_F_QUAL 48
`define SM_F_SCAN 56
`define SM_F_LAST 72
`define SM_F_FIRST 73
`define SM_WORD_W 74
`define SM_FIFO_DEPTH 32
`define SM_FIFO_AW 5

// ------------------------------------------------------------
// Timing: one scan at 600 Hz, 1.67 ms, clock period 5 ns
// ------------------------------------------------------------
`define SM_SCAN_RATE_HZ 600
`define SM_SCAN_PERIOD_NS 1670000
`define SM_CLK_PERIOD_NS 5
`define SM_GAP_W 21
`define SM_GAP_SCANS 2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SM_RST_CNT 8'h00
`define SM_RST_IDX 10'h000
`define SM_RST_SCAN 16'h0000
`define SM_RST_DIST 16'h0000
`define SM_RST_GAP 21'h000000
`define SM_ONE_CNT 8'h01
`define SM_ONE_IDX 10'h001

`endif

//--- hw/scan_mean_decimate.v
`timescale 1ns/1ps
// Contract
// - When enabled, average distance per angular position over a configured scan count.
// - Group scans in non-overlapping blocks; one averaged profile per block.
// - After telegram confirm, first output waits until a full block is collected.
// - Scan counter of each output carries the block's first scan number.
// - Zero distances are invalid; excluded from sum and divisor.
// - Remission, angle correction, quality take the block's first scan values.
// - One scan every 1.67 ms at 600 Hz; delay is period times count.
// - With median stage active, no delay beyond the averaging count is added.
// - Native step 1/12 degree; output step only integer multiples of it.
// - At 1 degree over 70 degrees, keep one point in every twelve.
// - Thinning only drops points; retained values and acquisition unchanged.
// - Averaging takes gloss compensation output and feeds angular thinning.
`include "scan_mean_regs.vh"

// ------------------------------------------------------------
// Synchronous FIFO with registered ready on the write side.
// ------------------------------------------------------------
module scan_mean_fifo #(
  parameter WIDTH = `SM_WORD_W,
  parameter DEPTH = `SM_FIFO_DEPTH,
  parameter AW = `SM_FIFO_AW
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  input wire [WIDTH-1:0] wr_data_in,
  output wire rd_valid_out,
  input wire rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q, rd_ptr_q;
  reg [AW:0] count_q;
  wire [AW:0] count_d;
  reg ready_q;
  wire do_wr, do_rd;

  // Handshakes on both sides; full and empty follow the word count.
  assign do_wr = wr_valid_in && ready_q;
  assign do_rd = rd_ready_in && (count_q != {(AW+1){1'b0}});
  assign rd_valid_out = (count_q != {(AW+1){1'b0}});
  assign rd_data_out = mem[rd_ptr_q];
  assign wr_ready_out = ready_q;

  // Next count; ready is registered from it so full is exact.
  assign count_d = count_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

  // Pointer, count and ready registers.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      ready_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ready_q <= (count_d != DEPTH[AW:0]);
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Storage is written without reset.
  always @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_q] <= wr_data_in;
    end
  end
endmodule

// ------------------------------------------------------------
// Scan averaging and angular thinning stage.
// ------------------------------------------------------------
module scan_mean_decimate #(
  parameter SCAN_PERIOD_CYC = `SM_SCAN_PERIOD_NS / `SM_CLK_PERIOD_NS
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire avg_enable_in,
  input wire [`SM_CNT_W-1:0] avg_scans_in,
  input wire [`SM_CNT_W-1:0] ang_step_in,
  input wire telegram_confirmed_in,
  input wire pt_valid_in,
  output wire pt_ready_out,
  input wire pt_first_in,
  input wire pt_last_in,
  input wire [`SM_DIST_W-1:0] dist_in,
  input wire [`SM_RSSI_W-1:0] rssi_in,
  input wire [`SM_ANG_W-1:0] angcorr_in,
  input wire [`SM_QUAL_W-1:0] quality_in,
  input wire [`SM_SCAN_W-1:0] scan_num_in,
  output wire mean_valid_out,
  input wire mean_ready_in,
  output wire mean_first_out,
  output wire mean_last_out,
  output wire [`SM_DIST_W-1:0] mean_dist_out,
  output wire [`SM_RSSI_W-1:0] mean_rssi_out,
  output wire [`SM_ANG_W-1:0] mean_angcorr_out,
  output wire [`SM_QUAL_W-1:0] mean_quality_out,
  output wire [`SM_SCAN_W-1:0] mean_scan_num_out,
  output wire scan_gap_out
);
  // Truncating mean; no valid sample gives zero.
  function [`SM_DIST_W-1:0] mean_of;
    input [`SM_SUM_W-1:0] sum;
    input [`SM_CNT_W-1:0] cnt;
    reg [`SM_SUM_W-1:0] q;
    begin
      q = {`SM_SUM_W{1'b0}};
      if (cnt != `SM_RST_CNT) begin
        q = sum / {{(`SM_SUM_W-`SM_CNT_W){1'b0}}, cnt};
      end
      mean_of = q[`SM_DIST_W-1:0];
    end
  endfunction

  // A configured count or step of zero acts as one.
  function [`SM_CNT_W-1:0] at_least_one;
    input [`SM_CNT_W-1:0] v;
    begin
      at_least_one = (v == `SM_RST_CNT) ? `SM_ONE_CNT : v;
    end
  endfunction

  // ------------------------------------------------------------
  // Input buffer; its ready is the upstream back-pressure.
  // ------------------------------------------------------------
  wire [`SM_WORD_W-1:0] in_word, buf_word;
  wire buf_valid, pop;
  reg out_valid_q;

  // Fields are packed in fixed positions of one buffer word.
  assign in_word = {pt_first_in, pt_last_in, scan_num_in, quality_in, angcorr_in, rssi_in,
    dist_in};

  scan_mean_fifo #(.WIDTH(`SM_WORD_W), .DEPTH(`SM_FIFO_DEPTH), .AW(`SM_FIFO_AW)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_valid_in(pt_valid_in),
    .wr_ready_out(pt_ready_out),
    .wr_data_in(in_word),
    .rd_valid_out(buf_valid),
    .rd_ready_in(pop),
    .rd_data_out(buf_word)
  );

  // A point leaves the buffer only when the output register can take it.
  assign pop = buf_valid && (!out_valid_q || mean_ready_in);

  wire [`SM_DIST_W-1:0] b_dist = buf_word[`SM_F_DIST +: `SM_DIST_W];
  wire [`SM_RSSI_W-1:0] b_rssi = buf_word[`SM_F_RSSI +: `SM_RSSI_W];
  wire [`SM_ANG_W-1:0] b_ang = buf_word[`SM_F_ANG +: `SM_ANG_W];
  wire [`SM_QUAL_W-1:0] b_qual = buf_word[`SM_F_QUAL +: `SM_QUAL_W];
  wire [`SM_SCAN_W-1:0] b_scan = buf_word[`SM_F_SCAN +: `SM_SCAN_W];
  wire b_last = buf_word[`SM_F_LAST];
  wire b_first = buf_word[`SM_F_FIRST];

  // ------------------------------------------------------------
  // Per-position accumulators for one block of scans.
  // ------------------------------------------------------------
  reg [`SM_SUM_W-1:0] sum_mem [0:`SM_MAX_POINTS-1];
  reg [`SM_CNT_W-1:0] cnt_mem [0:`SM_MAX_POINTS-1];
  reg [`SM_RSSI_W-1:0] rssi_mem [0:`SM_MAX_POINTS-1];
  reg [`SM_ANG_W-1:0] ang_mem [0:`SM_MAX_POINTS-1];
  reg [`SM_QUAL_W-1:0] qual_mem [0:`SM_MAX_POINTS-1];

  // Registers that track the scan in the block, the position and the thinning phase.
  reg run_q, emit_first_q, run_d;
  reg [`SM_CNT_W-1:0] next_scan_q, cur_scan_q, blk_len_q, step_q, thin_q;
  reg [`SM_CNT_W-1:0] cur_d, len_d, step_d, thin_d;
  reg [`SM_IDX_W-1:0] idx_q, idx_d;
  reg [`SM_SCAN_W-1:0] blk_num_q, num_d;
  wire in_range, keep, last_of_block, emit;

  // Scan framing: a first point opens a scan and may open a block.
  always @* begin
    run_d = run_q;
    cur_d = cur_scan_q;
    len_d = blk_len_q;
    step_d = step_q;
    idx_d = idx_q + `SM_ONE_IDX;
    thin_d = thin_q + `SM_ONE_CNT;
    num_d = blk_num_q;
    if (thin_d == step_q) begin
      thin_d = `SM_RST_CNT;
    end
    if (b_first) begin
      idx_d = `SM_RST_IDX;
      thin_d = `SM_RST_CNT;
      step_d = at_least_one(ang_step_in);
      run_d = telegram_confirmed_in;
      cur_d = run_q ? next_scan_q : `SM_RST_CNT;
      if (cur_d == `SM_RST_CNT) begin
        len_d = avg_enable_in ? at_least_one(avg_scans_in) : `SM_ONE_CNT;
        num_d = b_scan;
      end
    end
  end

  // Thinning keeps every step-th native point starting at position 0.
  assign in_range = (idx_d <= `SM_LAST_INDEX);
  assign keep = (thin_d == `SM_RST_CNT);
  assign last_of_block = (cur_d == len_d - `SM_ONE_CNT);
  assign emit = pop && run_d && last_of_block && keep && in_range;

  // Bookkeeping registers advance once per point taken from the buffer.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_q <= 1'b0;
      next_scan_q <= `SM_RST_CNT;
      cur_scan_q <= `SM_RST_CNT;
      blk_len_q <= `SM_ONE_CNT;
      step_q <= `SM_ONE_CNT;
      idx_q <= `SM_RST_IDX;
      thin_q <= `SM_RST_CNT;
      blk_num_q <= `SM_RST_SCAN;
      emit_first_q <= 1'b0;
    end else if (pop) begin
      run_q <= run_d;
      cur_scan_q <= cur_d;
      blk_len_q <= len_d;
      step_q <= step_d;
      idx_q <= idx_d;
      thin_q <= thin_d;
      blk_num_q <= num_d;
      emit_first_q <= (emit_first_q || b_first) && !emit;
      // Next scan index wraps after the block's last scan.
      if (!run_d) begin
        next_scan_q <= `SM_RST_CNT;
      end else if (b_last) begin
        next_scan_q <= last_of_block ? `SM_RST_CNT : cur_d + `SM_ONE_CNT;
      end
    end
  end

  // Accumulation: zero samples add nothing to the sum or to the count.
  wire valid_sample = (b_dist != `SM_RST_DIST);
  wire [`SM_SUM_W-1:0] b_dist_ext = {{(`SM_SUM_W-`SM_DIST_W){1'b0}}, b_dist};
  wire [`SM_CNT_W-1:0] b_cnt = valid_sample ? `SM_ONE_CNT : `SM_RST_CNT;
  wire opening = (cur_d == `SM_RST_CNT);
  wire [`SM_SUM_W-1:0] sum_new = opening ? b_dist_ext : sum_mem[idx_d] + b_dist_ext;
  wire [`SM_CNT_W-1:0] cnt_new = opening ? b_cnt : cnt_mem[idx_d] + b_cnt;

  // Store running sums and the first scan's other channels.
  always @(posedge sys_clk_in) begin
    if (pop && run_d && in_range) begin
      sum_mem[idx_d] <= sum_new;
      cnt_mem[idx_d] <= cnt_new;
      if (opening) begin
        rssi_mem[idx_d] <= b_rssi;
        ang_mem[idx_d] <= b_ang;
        qual_mem[idx_d] <= b_qual;
      end
    end
  end

  // ------------------------------------------------------------
  // Output register
  // ------------------------------------------------------------
  reg out_first_q, out_last_q;
  reg [`SM_DIST_W-1:0] out_dist_q;
  reg [`SM_RSSI_W-1:0] out_rssi_q;
  reg [`SM_ANG_W-1:0] out_ang_q;
  reg [`SM_QUAL_W-1:0] out_qual_q;
  reg [`SM_SCAN_W-1:0] out_num_q;

  // A result is held until taken; the last scan of a block produces it.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      out_valid_q <= 1'b0;
      out_first_q <= 1'b0;
      out_last_q <= 1'b0;
      out_dist_q <= `SM_RST_DIST;
      out_rssi_q <= `SM_RST_DIST;
      out_ang_q <= `SM_RST_DIST;
      out_qual_q <= `SM_RST_CNT;
      out_num_q <= `SM_RST_SCAN;
    end else begin
      if (mean_ready_in) begin
        out_valid_q <= 1'b0;
      end
      if (emit) begin
        out_valid_q <= 1'b1;
        out_first_q <= b_first || emit_first_q;
        out_last_q <= b_last;
        out_dist_q <= mean_of(sum_new, cnt_new);
        out_rssi_q <= opening ? b_rssi : rssi_mem[idx_d];
        out_ang_q <= opening ? b_ang : ang_mem[idx_d];
        out_qual_q <= opening ? b_qual : qual_mem[idx_d];
        out_num_q <= num_d;
      end
    end
  end

  assign mean_valid_out = out_valid_q;
  assign mean_first_out = out_first_q;
  assign mean_last_out = out_last_q;
  assign mean_dist_out = out_dist_q;
  assign mean_rssi_out = out_rssi_q;
  assign mean_angcorr_out = out_ang_q;
  assign mean_quality_out = out_qual_q;
  assign mean_scan_num_out = out_num_q;

  // ------------------------------------------------------------
  // Scan rate watch: flags a gap longer than two scan periods.
  // ------------------------------------------------------------
  localparam integer GAP_FULL = SCAN_PERIOD_CYC * `SM_GAP_SCANS;
  localparam [`SM_GAP_W-1:0] GAP_LIMIT = GAP_FULL[`SM_GAP_W-1:0];
  reg [`SM_GAP_W-1:0] gap_q;
  reg gap_flag_q;

  // The counter restarts on every accepted scan start.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_q <= `SM_RST_GAP;
      gap_flag_q <= 1'b0;
    end else if (pop && b_first) begin
      gap_q <= `SM_RST_GAP;
      gap_flag_q <= 1'b0;
    end else if (run_q && gap_q != GAP_LIMIT) begin
      gap_q <= gap_q + {{(`SM_GAP_W-1){1'b0}}, 1'b1};
    end else if (run_q) begin
      gap_flag_q <= 1'b1;
    end
  end

  // The stage holds no extra scan of its own beyond the block.
  assign scan_gap_out = gap_flag_q;
endmodule

//--- test/scan_mean_decimate_assertions.sv
`timescale 1ns/1ps
`include "scan_mean_regs.vh"
// ------------------------------------------------------------
// Port checker for the averaging and thinning stage.
// ------------------------------------------------------------
module scan_mean_decimate_checker #(
  parameter SCAN_PERIOD_CYC = 334000
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire avg_enable_in,
  input wire [`SM_CNT_W-1:0] avg_scans_in,
  input wire [`SM_CNT_W-1:0] ang_step_in,
  input wire telegram_confirmed_in,
  input wire pt_valid_in,
  input wire pt_ready_out,
  input wire pt_first_in,
  input wire mean_valid_out,
  input wire mean_ready_in,
  input wire mean_first_out,
  input wire mean_last_out,
  input wire [`SM_DIST_W-1:0] mean_dist_out,
  input wire [`SM_SCAN_W-1:0] mean_scan_num_out,
  input wire scan_gap_out
);
  wire take_w = pt_valid_in && pt_ready_out;
  wire out_w = mean_valid_out && mean_ready_in;
  reg [31:0] in_q;
  reg [31:0] out_q;
  reg [31:0] gap_q;
  reg [`SM_SCAN_W-1:0] scan_q;
  reg last_q;

  // Counts points in and out, cycles since a scan start, and the last output seen.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      in_q <= 32'h0;
      out_q <= 32'h0;
      gap_q <= 32'h0;
      scan_q <= 16'h0000;
      last_q <= 1'b0;
    end else begin
      in_q <= in_q + {31'h0, take_w};
      out_q <= out_q + {31'h0, out_w};
      gap_q <= (take_w && pt_first_in) ? 32'h0 : gap_q + 32'h1;
      if (out_w) begin
        scan_q <= mean_scan_num_out;
        last_q <= mean_last_out;
      end
    end
  end

  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_pass_start;
    take_w && pt_first_in && telegram_confirmed_in && avg_enable_in &&
      avg_scans_in <= 8'h01 && ang_step_in <= 8'h01;
  endsequence
  sequence s_first_shown;
    mean_valid_out && mean_first_out;
  endsequence

  a_reset_release: assert property (
    $rose(resetn_in) |-> !pt_ready_out ##1 pt_ready_out)
    else $error("input ready late after reset");
  a_hold_stall: assert property (
    mean_valid_out && !mean_ready_in |=>
      mean_valid_out && $stable(mean_dist_out) && $stable(mean_scan_num_out))
    else $error("output changed while stalled");
  a_out_bounded: assert property (out_w |-> out_q < in_q)
    else $error("more points out than in");
  a_scan_tag: assert property (
    out_w && !mean_first_out |-> mean_scan_num_out == scan_q)
    else $error("scan number changed within a profile");
  a_last_first: assert property (out_w && last_q |-> mean_first_out)
    else $error("profile after a last point lacks first mark");
  a_pass_prompt: assert property (s_pass_start |-> ##[1:300] s_first_shown)
    else $error("single scan block delayed");
  a_gap_late: assert property (scan_gap_out |-> gap_q >= SCAN_PERIOD_CYC)
    else $error("gap flag too early");
  a_gap_clear: assert property (take_w && pt_first_in |-> ##3 !scan_gap_out)
    else $error("gap flag kept after scan start");
endmodule

//--- test/scan_sink_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Telegram side: takes points promptly, at random, or not at all.
// ------------------------------------------------------------
module scan_sink_model (
  input wire sys_clk_in,
  input wire [1:0] mode_in,
  output reg ready_out = 1'b0
);
  reg [15:0] seed_q = 16'h00A7;

  // Ready moves at the falling edge so it is settled at the sampling edge.
  always @(negedge sys_clk_in) begin
    seed_q <= {seed_q[14:0], seed_q[15] ^ seed_q[13] ^ seed_q[12] ^ seed_q[10]};
    ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && seed_q[1:0] != 2'h0);
  end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
`include "scan_mean_regs.vh"
// ------------------------------------------------------------
// Bench for the averaging and thinning stage.
// ------------------------------------------------------------
module tb;
  localparam int P = 1000;
  reg sys_clk_in = 1'b0;
  reg resetn_in = 1'b0;
  reg avg_enable_in = 1'b1;
  reg [7:0] avg_scans_in = 8'h01;
  reg [7:0] ang_step_in = 8'h01;
  reg telegram_confirmed_in = 1'b1;
  reg pt_valid_in = 1'b0;
  reg pt_first_in = 1'b0;
  reg pt_last_in = 1'b0;
  reg [15:0] dist_in = 16'h0000;
  reg [15:0] rssi_in = 16'h0000;
  reg [15:0] angcorr_in = 16'h0000;
  reg [7:0] quality_in = 8'h00;
  reg [15:0] scan_num_in = 16'h0000;
  wire pt_ready_out;
  wire mean_valid_out;
  wire mean_ready_in;
  wire mean_first_out;
  wire mean_last_out;
  wire scan_gap_out;
  wire [15:0] mean_dist_out;
  wire [15:0] mean_rssi_out;
  wire [15:0] mean_angcorr_out;
  wire [15:0] mean_scan_num_out;
  wire [7:0] mean_quality_out;
  reg [1:0] sink_mode = 2'h0;
  reg [15:0] lfsr_q = 16'h002B;
  reg [15:0] scan_no = 16'h0100;
  reg [15:0] head_scan = 16'h0000;
  reg refused = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int out_n = 0;
  int sum_a[0:840];
  int cnt_a[0:840];
  logic [39:0] head_a[0:840];
  logic [73:0] exp_q[$];

  scan_mean_decimate #(.SCAN_PERIOD_CYC(P)) scan_mean_decimate_inst (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .avg_enable_in(avg_enable_in),
    .avg_scans_in(avg_scans_in),
    .ang_step_in(ang_step_in),
    .telegram_confirmed_in(telegram_confirmed_in),
    .pt_valid_in(pt_valid_in),
    .pt_ready_out(pt_ready_out),
    .pt_first_in(pt_first_in),
    .pt_last_in(pt_last_in),
    .dist_in(dist_in),
    .rssi_in(rssi_in),
    .angcorr_in(angcorr_in),
    .quality_in(quality_in),
    .scan_num_in(scan_num_in),
    .mean_valid_out(mean_valid_out),
    .mean_ready_in(mean_ready_in),
    .mean_first_out(mean_first_out),
    .mean_last_out(mean_last_out),
    .mean_dist_out(mean_dist_out),
    .mean_rssi_out(mean_rssi_out),
    .mean_angcorr_out(mean_angcorr_out),
    .mean_quality_out(mean_quality_out),
    .mean_scan_num_out(mean_scan_num_out),
    .scan_gap_out(scan_gap_out)
  );
  scan_sink_model scan_sink_model_inst (.sys_clk_in(sys_clk_in), .mode_in(sink_mode),
    .ready_out(mean_ready_in));

  // Free running clock.
  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  function automatic logic [15:0] mean_of(input int s, input int c);
    return (c == 0) ? 16'h0000 : 16'(s / c);
  endfunction

  task automatic chk(input logic [73:0] got, input logic [73:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Offers one scan and records what the output must show for it.
  task automatic send_scan(input int n, input int k, input int c, input int s, input bit conf);
    logic [15:0] d;
    for (int i = 0; i < n; i++) begin
      d = rnd();
      if (d[1:0] == 2'h0 || i == 1) d = 16'h0000;
      pt_valid_in = 1'b1;
      pt_first_in = (i == 0);
      pt_last_in = (i == n - 1);
      telegram_confirmed_in = conf;
      dist_in = d;
      rssi_in = rnd();
      angcorr_in = rnd();
      quality_in = rssi_in[7:0] ^ angcorr_in[15:8];
      scan_num_in = scan_no;
      if (k == 0) begin
        sum_a[i] = 0;
        cnt_a[i] = 0;
        head_a[i] = {rssi_in, angcorr_in, quality_in};
        head_scan = scan_no;
      end
      sum_a[i] += d;
      cnt_a[i] += (d != 16'h0000);
      if (conf && k == c - 1 && i % s == 0)
        exp_q.push_back({i == 0, i == n - 1, mean_of(sum_a[i], cnt_a[i]), head_a[i], head_scan});
      @(posedge sys_clk_in);
      while (!pt_ready_out) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
    end
    pt_valid_in = 1'b0;
    scan_no++;
    repeat (20) @(negedge sys_clk_in);
  endtask

  task automatic run_block(input int n, input int c, input int s);
    avg_scans_in = 8'(c);
    ang_step_in = 8'(s);
    for (int k = 0; k < c; k++) send_scan(n, k, c, s, 1'b1);
  endtask

  task automatic drain();
    for (int t = 0; t < 5000 && exp_q.size() != 0; t++) @(negedge sys_clk_in);
    chk(74'(exp_q.size()), 74'h0);
  endtask

  // Compares each handed-over point with the model and notes refusals.
  always @(posedge sys_clk_in) begin
    if (pt_valid_in && !pt_ready_out) refused = 1'b1;
    if (mean_valid_out && mean_ready_in) begin
      out_n++;
      if (exp_q.size() == 0) chk(74'h0, 74'h1);
      else chk({mean_first_out, mean_last_out, mean_dist_out, mean_rssi_out,
        mean_angcorr_out, mean_quality_out, mean_scan_num_out}, exp_q.pop_front());
    end
  end

  // Main sequence: pass-through, averaging blocks, dropped scan, thinning, fill, gap.
  initial begin
    repeat (20) @(negedge sys_clk_in);
    resetn_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    run_block(16, 1, 1);
    avg_enable_in = 1'b0;
    avg_scans_in = 8'h04;
    ang_step_in = 8'h00;
    send_scan(10, 0, 1, 1, 1'b1);
    avg_enable_in = 1'b1;
    avg_scans_in = 8'h00;
    send_scan(10, 0, 1, 1, 1'b1);
    sink_mode = 2'h1;
    for (int j = 0; j < 3; j++) run_block(20, j + 2, 2 * j + 1);
    run_block(12, 5, 1);
    drain();
    avg_scans_in = 8'h03;
    send_scan(12, 0, 3, 1, 1'b1);
    send_scan(12, 0, 3, 1, 1'b0);
    run_block(12, 3, 1);
    drain();
    sink_mode = 2'h0;
    out_n = 0;
    run_block(841, 1, 12);
    drain();
    chk(74'(out_n), 74'h47);
    sink_mode = 2'h2;
    refused = 1'b0;
    fork
      run_block(40, 1, 1);
      begin
        repeat (80) @(negedge sys_clk_in);
        sink_mode = 2'h1;
      end
    join
    drain();
    chk(74'({refused, pt_ready_out}), 74'h3);
    avg_scans_in = 8'h02;
    send_scan(8, 0, 2, 1, 1'b1);
    repeat (2 * P + 20) @(negedge sys_clk_in);
    chk(74'(scan_gap_out), 74'h1);
    wrap_up();
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule

bind scan_mean_decimate scan_mean_decimate_checker #(.SCAN_PERIOD_CYC(SCAN_PERIOD_CYC))
  scan_mean_decimate_checker_inst (
  .sys_clk_in(sys_clk_in),
  .resetn_in(resetn_in),
  .avg_enable_in(avg_enable_in),
  .avg_scans_in(avg_scans_in),
  .ang_step_in(ang_step_in),
  .telegram_confirmed_in(telegram_confirmed_in),
  .pt_valid_in(pt_valid_in),
  .pt_ready_out(pt_ready_out),
  .pt_first_in(pt_first_in),
  .mean_valid_out(mean_valid_out),
  .mean_ready_in(mean_ready_in),
  .mean_first_out(mean_first_out),
  .mean_last_out(mean_last_out),
  .mean_dist_out(mean_dist_out),
  .mean_scan_num_out(mean_scan_num_out),
  .scan_gap_out(scan_gap_out)
);
